// *** rtl/bit_fifo.sv ***
// Small synchronous FIFO carrying resolved result bits to the shifter
`timescale 1ns/1ns
module bit_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 16
) (
	input wire logic i_clk, // Core clock
	input wire logic i_nrst, // Async reset, active low
	input wire logic i_flush, // Sync clear of all entries
	input wire logic i_valid, // Write request
	output logic o_ready, // Room for a write
	input wire logic [WIDTH-1:0] i_data, // Write data
	output logic o_valid, // Entry available
	input wire logic i_ready, // Read accept
	output logic [WIDTH-1:0] o_data // Head entry
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH]; // Storage
	logic [AW:0] wr_ptr_reg; // Write pointer with wrap bit
	logic [AW:0] rd_ptr_reg; // Read pointer with wrap bit
	wire logic full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
		(wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
	wire logic empty = (wr_ptr_reg == rd_ptr_reg);
	wire logic do_wr = i_valid && !full;
	wire logic do_rd = i_ready && !empty;

	assign o_ready = !full;
	assign o_valid = !empty;
	assign o_data = mem[rd_ptr_reg[AW-1:0]];

	// Storage needs no reset; pointers define what is valid
	always_ff @(posedge i_clk) begin
		if (do_wr) begin
			mem[wr_ptr_reg[AW-1:0]] <= i_data;
		end
	end

	// Pointer update; a flush wins so a new frame starts empty
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else if (i_flush) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (do_rd) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end
endmodule // bit_fifo

// *** rtl/sar_adc_pkg.sv ***
// Package with constants, states and carriers for the converter readout
package sar_adc_pkg;
	localparam int RES_BITS = 16; // Result width
	localparam int LEAD_ZEROS = 8; // Zero bits ahead of the MSB
	localparam int FALLS_PER_FRAME = 24; // Falls to read a whole frame
	localparam int FALL_HOLD = 6; // Fall that ends acquisition
	localparam int CNT_W = 5; // Width of the fall counter
	localparam logic [4:0] FALL_HOLD_C = 5'h06; // Hold at this fall
	localparam logic [4:0] FALL_SAR_FIRST = 5'h07; // First decision
	localparam logic [4:0] FALL_SAR_LAST = 5'h16; // Last decision
	localparam logic [4:0] FALL_DATA_FIRST = 5'h08; // First result bit out
	localparam logic [4:0] FALL_DATA_LAST = 5'h17; // Last result bit out
	localparam logic [4:0] FALL_CNT_MAX = 5'h1F; // Counter saturates
	localparam logic [3:0] BIT_MSB = 4'hF; // Index of the MSB
	localparam logic [15:0] CODE_ZERO = 16'h0000; // Reset code
	localparam logic [15:0] CODE_MSB = 16'h8000; // First trial code
	localparam int FIFO_DEPTH = 16; // Bit buffer depth
	localparam int FIFO_WIDTH = 1; // Bit buffer width
	localparam int MCLK_PERIOD_NS = 10; // Core clock period
	localparam int ACQ_TIME_NS = 1100; // Least acquisition interval
	localparam int ACQ_CYCLES =
		(ACQ_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS; // Rounded up
	localparam int CS_HIGH_NS = 50; // Least select-high time
	localparam int CS_HIGH_CYCLES =
		(CS_HIGH_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS; // Rounded up

	// Gray-coded conversion states along the usual path
	typedef enum logic [1:0] {
		ST_SHUTDOWN = 2'h0,
		ST_ACQUIRE = 2'h1,
		ST_CONVERT = 2'h3,
		ST_DONE = 2'h2
	} conv_state_e;

	// Pin levels that pass the synchroniser together
	typedef struct packed {
		logic cs_n; // Select, active low
		logic sclk; // Serial clock level
		logic cmp; // Comparator: input above trial level
	} pin_sync_s;
endpackage

// *** rtl/sar_adc_serial_readout.sv ***
// Control and serial readout of a 16-bit successive-approximation converter
`timescale 1ns/1ns
module sar_adc_serial_readout
	import sar_adc_pkg::*;
#(
	parameter int RES = RES_BITS, // Result width
	parameter int BUF_DEPTH = FIFO_DEPTH // Bit buffer depth
) (
	input wire logic i_mclk, // Core clock, 100 MHz
	input wire logic i_nrst, // Async reset, active low
	input wire logic i_cs_n, // Select pin, active low
	input wire logic i_sclk, // Serial clock pin from host
	input wire logic i_cmp_above, // Comparator: input above trial code
	output logic o_dout, // Serial data out
	output logic o_dout_oe, // Drive enable for serial data
	output logic o_powered, // Analog section powered
	output logic o_track, // Track switches closed to analog_input
	output logic [RES-1:0] o_dac_code, // Trial code to sampling_cap_array
	output logic [RES-1:0] o_result, // Last complete result
	output logic o_result_valid // One-cycle pulse with new result
);
	// Synchroniser stages; stage one feeds only stage two
	pin_sync_s sync1_reg;
	pin_sync_s sync2_reg;
	pin_sync_s sync3_reg; // Delayed copy for edge finding
	conv_state_e state_reg; // Conversion state
	conv_state_e state_next;
	logic [CNT_W-1:0] fall_cnt_reg; // Serial clock falls in this frame
	logic [CNT_W-1:0] fall_cnt_next;
	logic [RES-1:0] sar_reg; // Trial and decided bits
	logic [RES-1:0] sar_next;
	logic [3:0] bit_idx_reg; // Bit under trial
	logic [3:0] bit_idx_next;
	logic dout_next;

	// Decoded events on the synchronised pins
	wire pin_sync_s pin_in = '{cs_n: i_cs_n, sclk: i_sclk,
		cmp: i_cmp_above};
	wire logic cs_high = sync2_reg.cs_n;
	wire logic cs_fall = !sync2_reg.cs_n && sync3_reg.cs_n;
	wire logic sclk_fall = !sync2_reg.sclk && sync3_reg.sclk;
	// Counter saturates so long frames never wrap back into the windows
	wire logic [CNT_W-1:0] cnt_after = (fall_cnt_reg == FALL_CNT_MAX) ?
		fall_cnt_reg : fall_cnt_reg + 1'b1;
	wire logic at_hold = sclk_fall && (cnt_after == FALL_HOLD_C);
	wire logic in_sar_win = (cnt_after >= FALL_SAR_FIRST) &&
		(cnt_after <= FALL_SAR_LAST);
	wire logic in_data_win = (cnt_after >= FALL_DATA_FIRST) &&
		(cnt_after <= FALL_DATA_LAST);
	wire logic active = !cs_high && (state_reg != ST_SHUTDOWN);
	wire logic fifo_ready;
	wire logic fifo_valid;
	wire logic [FIFO_WIDTH-1:0] fifo_data;
	// A decision is only taken when the buffer has room; it never fills
	// in normal use, but a full buffer must stall and not drop a bit
	wire logic sar_step = active && (state_reg == ST_CONVERT) &&
		sclk_fall && in_sar_win && fifo_ready;
	wire logic last_step = sar_step && (bit_idx_reg == 4'h0);
	wire logic shift_bit = active && sclk_fall && in_data_win;
	// Comparator high keeps the trial bit: straight binary code
	wire logic decided = sync2_reg.cmp;

	// Two-stage synchroniser plus edge stage for all pins
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			sync1_reg <= '{cs_n: 1'b1, sclk: 1'b0, cmp: 1'b0};
			sync2_reg <= '{cs_n: 1'b1, sclk: 1'b0, cmp: 1'b0};
			sync3_reg <= '{cs_n: 1'b1, sclk: 1'b0, cmp: 1'b0};
		end else begin
			sync1_reg <= pin_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// Next state; select high overrides every state at once
	always_comb begin
		state_next = state_reg;
		// Only a select fall leaves shutdown, so stray clocks are harmless
		case (state_reg)
			ST_SHUTDOWN: begin
				if (cs_fall) begin
					state_next = ST_ACQUIRE;
				end
			end
			ST_ACQUIRE: begin
				if (at_hold) begin
					state_next = ST_CONVERT;
				end
			end
			ST_CONVERT: begin
				if (last_step) begin
					state_next = ST_DONE;
				end
			end
			ST_DONE: begin
				state_next = ST_DONE; // Extra falls change nothing
			end
			default: begin
				state_next = ST_SHUTDOWN;
			end
		endcase
		if (cs_high) begin
			state_next = ST_SHUTDOWN;
		end
	end

	// Fall counter, cleared whenever select is high
	always_comb begin
		fall_cnt_next = fall_cnt_reg;
		if (cs_high || cs_fall) begin
			fall_cnt_next = '0;
		end else if (sclk_fall) begin
			fall_cnt_next = cnt_after;
		end
	end

	// Successive approximation: set trial, then keep or drop each bit
	always_comb begin
		sar_next = sar_reg;
		bit_idx_next = bit_idx_reg;
		if (cs_high) begin
			sar_next = CODE_ZERO;
			bit_idx_next = BIT_MSB;
		end else if (at_hold && state_reg == ST_ACQUIRE) begin
			sar_next = CODE_MSB;
			bit_idx_next = BIT_MSB;
		end else if (sar_step) begin
			sar_next[bit_idx_reg] = decided;
			// Next lower bit becomes the new trial
			if (bit_idx_reg != 4'h0) begin
				sar_next[bit_idx_reg - 4'h1] = 1'b1;
				bit_idx_next = bit_idx_reg - 4'h1;
			end
		end
	end

	// Serial data: zeros first, buffered result bits, then zeros again
	always_comb begin
		// Holding the old bit keeps the pin quiet between clock falls
		dout_next = o_dout;
		if (cs_high || cs_fall) begin
			dout_next = 1'b0;
		end else if (sclk_fall) begin
			dout_next = shift_bit && fifo_valid && fifo_data[0];
		end
	end

	// Resolved bits wait in the buffer until their output fall
	bit_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(BUF_DEPTH)
	) u_bit_fifo (
		.i_clk(i_mclk),
		.i_nrst(i_nrst),
		.i_flush(cs_high),
		.i_valid(sar_step),
		.o_ready(fifo_ready),
		.i_data(decided),
		.o_valid(fifo_valid),
		.i_ready(shift_bit),
		.o_data(fifo_data)
	);

	// State, counters and trial code
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_reg <= ST_SHUTDOWN;
			fall_cnt_reg <= '0;
			sar_reg <= CODE_ZERO;
			bit_idx_reg <= BIT_MSB;
		end else begin
			state_reg <= state_next;
			fall_cnt_reg <= fall_cnt_next;
			sar_reg <= sar_next;
			bit_idx_reg <= bit_idx_next;
		end
	end

	// Pin and status outputs, all registered
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_dout <= 1'b0;
			o_dout_oe <= 1'b0;
			o_powered <= 1'b0;
			o_track <= 1'b0;
			o_dac_code <= CODE_ZERO;
		end else begin
			o_dout <= dout_next;
			o_dout_oe <= !cs_high;
			o_powered <= !cs_high;
			o_track <= (state_next == ST_ACQUIRE);
			o_dac_code <= sar_next;
		end
	end

	// Completed word for the core side, with a one-cycle strobe
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_result <= CODE_ZERO;
			o_result_valid <= 1'b0;
		end else begin
			o_result_valid <= last_step;
			if (last_step) begin
				o_result <= sar_next;
			end
		end
	end

	// Checks run on the core clock and rest while reset is held
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);

	sequence s_select_fall;
		cs_fall;
	endsequence
	sequence s_tracking;
		o_track [*1];
	endsequence

	sequence s_result_pulse;
		o_result_valid ##1 !o_result_valid;
	endsequence

	a_shutdown_power:
	assert property (cs_high |=> !o_powered && state_reg == ST_SHUTDOWN)
		else $error("select high did not shut down");
	a_start_track:
	assert property (s_select_fall and (state_reg == ST_SHUTDOWN)
		|=> s_tracking)
		else $error("select fall did not start acquisition");
	a_dout_on_fall:
	assert property (!sclk_fall && !cs_high && !cs_fall
		|=> $stable(o_dout))
		else $error("serial data changed without a clock fall");
	a_dout_hiz:
	assert property (cs_high |=> !o_dout_oe && !o_dout)
		else $error("output driven while select high");
	a_lead_zeros:
	assert property (sclk_fall && !in_data_win |=> !o_dout)
		else $error("nonzero bit outside result window");
	a_hold_sixth:
	assert property (at_hold && state_reg == ST_ACQUIRE && !cs_high
		|=> !o_track && o_dac_code == CODE_MSB)
		else $error("acquisition did not end at sixth fall");
	a_result_bits:
	assert property (o_result_valid |-> $past(fall_cnt_next) ==
		FALL_SAR_LAST && state_reg == ST_DONE)
		else $error("result not finished at last decision fall");
	a_extra_falls:
	assert property (state_reg == ST_DONE && !cs_high
		|=> $stable(o_result) && !o_result_valid)
		else $error("extra clock falls disturbed the converter");
	a_abort_clear:
	assert property (cs_high && state_reg == ST_CONVERT
		|=> state_reg == ST_SHUTDOWN ##1 o_dac_code == CODE_ZERO)
		else $error("select rise did not abort conversion");
	a_count_clear:
	assert property (cs_high |=> fall_cnt_reg == '0)
		else $error("fall counter not cleared while select high");

	// Decision bits must always find room; a stall would skew the frame
	a_buffer_room:
	assert property (state_reg == ST_CONVERT && sclk_fall && in_sar_win
		&& !cs_high |-> fifo_ready)
		else $error("bit buffer full at a decision fall");
	// Each output fall in the window hands out the buffer head
	a_msb_shift:
	assert property (shift_bit && fifo_valid
		|=> o_dout == $past(fifo_data[0]))
		else $error("serial bit differs from buffer head");
	// Acquisition is the only state with the track switches closed
	a_track_acquire:
	assert property (o_track |-> state_reg == ST_ACQUIRE)
		else $error("track switches closed outside acquisition");
	// Low select keeps the driver on and the analog side powered
	a_drive_select:
	assert property (!cs_high |=> o_dout_oe && o_powered)
		else $error("driver or power off while select low");
	// After the last decision only a select rise may change the code
	a_done_quiet:
	assert property (state_reg == ST_DONE && !cs_high
		|=> state_reg == ST_DONE && $stable(o_dac_code))
		else $error("extra falls moved the trial code");
	// The new-result strobe stands for exactly one cycle
	a_valid_pulse:
	assert property (o_result_valid |-> s_result_pulse)
		else $error("result strobe longer than one cycle");
endmodule // sar_adc_serial_readout

// *** tb/sar_adc_serial_readout_bench.sv ***
// Testbench for the converter control and serial readout
`timescale 1ns/1ns
module sar_adc_serial_readout_bench;
	import sar_adc_pkg::*;
	logic i_mclk, i_nrst, i_cmp_above, cs_n, sclk, sclk_d, dout_d, oe_d;
	logic o_dout, o_dout_oe, o_powered, o_track, o_result_valid;
	logic [15:0] o_dac_code, o_result, vin;
	logic [15:0] last_res; // Result of the last complete frame
	logic [31:0] lfsr; // Random source
	int n_fail, comparisons, n_valid, since_fall, nv0;
	logic fq[$]; // Reference serial stream of one frame
	sar_adc_serial_readout u_dut (.i_mclk(i_mclk), .i_nrst(i_nrst),
		.i_cs_n(cs_n), .i_sclk(sclk), .i_cmp_above(i_cmp_above),
		.o_dout(o_dout), .o_dout_oe(o_dout_oe), .o_powered(o_powered),
		.o_track(o_track), .o_dac_code(o_dac_code), .o_result(o_result),
		.o_result_valid(o_result_valid));
	sar_host_model u_host (.o_cs_n(cs_n), .o_sclk(sclk), .i_dout(o_dout),
		.i_dout_oe(o_dout_oe));
	// Core clock, 100 MHz
	always #5 i_mclk = ~i_mclk;
	function automatic logic [31:0] step(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		if (n_fail == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Analog side: input above the trial level keeps the bit set
	always @(negedge i_mclk) i_cmp_above <= (vin >= o_dac_code);
	// Result monitor and output timing, sampled where outputs have settled
	always @(negedge i_mclk) begin
		sclk_d <= sclk;
		dout_d <= o_dout;
		oe_d <= o_dout_oe;
		since_fall <= (sclk_d && !sclk) ? 0 : since_fall + 1;
		if (o_dout_oe && oe_d && o_dout !== dout_d)
			check(16'(since_fall < 6), 16'h1);
		if (o_result_valid === 1'b1) begin
			n_valid++;
			check(o_result, vin);
		end
	end
	// Watchdog sized well above the expected run of about 24 us
	initial begin
		#200000;
		n_fail++;
		stop_test;
	end
	initial begin
		{i_mclk, i_nrst, vin} = '0;
		lfsr = 32'h06C5;
		repeat (6) @(negedge i_mclk);
		i_nrst = 1'b1;
		// Frames: zero scale, full scale, an abort, then random inputs
		for (int i = 0; i < 6; i++) begin
			@(negedge i_mclk);
			lfsr = step(lfsr);
			vin = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : lfsr[15:0];
			nv0 = n_valid;
			fork
				u_host.frame(i == 2 ? 12 : 28);
				begin
					#450;
					check({o_powered, o_dout_oe, o_track, o_dout}, 16'hE);
					#1050;
					check(16'(o_track), 16'h0);
					check(o_dac_code, CODE_MSB);
				end
			join
			#50;
			check({o_powered, o_dout_oe, o_track, o_dout}, 16'h0);
			check(o_dac_code, CODE_ZERO);
			if (i == 2) begin
				check(16'(n_valid - nv0), 16'h0);
				check(o_result, last_res);
			end else begin
				check(16'(n_valid - nv0), 16'h1);
				check(o_result, vin);
				check(16'(u_host.rx[27:20]), 16'h0);
				check(u_host.rx[19:4], vin);
				check(16'(u_host.rx[3:0]), 16'h0);
				// Reference stream: eight zeros, result MSB first, zeros
				for (int k = 0; k < 28; k++)
					fq.push_back((k >= 8 && k < 24) ? vin[23 - k] : 1'b0);
				for (int k = 27; k >= 0; k--)
					check(16'(u_host.rx[k]), 16'(fq.pop_front()));
				last_res = vin;
			end
		end
		stop_test;
	end
endmodule // sar_adc_serial_readout_bench

// *** tb/sar_host_model.sv ***
// Host model that drives select and the serial clock and reads data
`timescale 1ns/1ns
module sar_host_model (
	output logic o_cs_n, // Select to device, active low
	output logic o_sclk, // Serial clock to device, idles low
	input wire logic i_dout, // Serial data from device
	input wire logic i_dout_oe // Device drives the data line
);
	logic [31:0] rx; // Bits read, newest in bit 0
	// Idle: deselected, clock standing still
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		rx = '0;
	end
	// One frame of n clocks; odd offsets keep pin edges off mclk edges
	task automatic frame(input int n);
		rx = '0;
		#52;
		o_cs_n = 1'b0;
		#602; // Clock held still to stretch acquisition
		for (int i = 0; i < n; i++) begin
			#62 o_sclk = 1'b1;
			// Undriven line reads as unknown, so it never matches
			rx = {rx[30:0], i_dout_oe ? i_dout : 1'bx};
			#63 o_sclk = 1'b0;
		end
		#100 o_cs_n = 1'b1;
	endtask
endmodule // sar_host_model
